//--- hdl/bgcf_pkg.sv
// Constants and carriers for the bridge general control field bank.
// Assumes config accesses arrive as aligned dwords with byte enables.
package bgcf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] BGCF_GEN_CTRL_OFS = 8'hD4;
  localparam logic [7:0] BGCF_RSVD_A_OFS   = 8'hD8;

  // ****************************************************************
  // Field positions in the general control word
  // ****************************************************************
  localparam int BGCF_PREF_OFF_BIT  = 19;
  localparam int BGCF_L0S_LSB       = 16;
  localparam int BGCF_L1_LSB        = 13;
  localparam int BGCF_VC_BIT        = 12;
  localparam int BGCF_CLK_STOP_BIT  = 11;
  localparam int BGCF_BEACON_BIT    = 10;
  localparam int BGCF_SCALE_LSB     = 8;
  localparam int BGCF_VALUE_LSB     = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0]  BGCF_L0S_RST    = 3'h0;
  localparam logic [2:0]  BGCF_L1_RST     = 3'h0;
  localparam logic [1:0]  BGCF_SCALE_RST  = 2'h0;
  localparam logic [7:0]  BGCF_VALUE_RST  = 8'h5F;
  localparam logic [7:0]  BGCF_RSVD_RST   = 8'h00;
  localparam logic [11:0] BGCF_AER_NEXT_OFF = 12'h000;
  localparam logic [11:0] BGCF_AER_NEXT_ON  = 12'h150;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bgcf_cfg_req_t;

  typedef struct packed {
    logic        rvalid;
    logic [31:0] rdata;
  } bgcf_cfg_rsp_t;

  typedef struct packed {
    logic [2:0]  cap_shallow_exit_copy;
    logic [2:0]  cap_deep_exit_copy;
    logic [11:0] aer_next_cap;
    logic        prefetch_single_dword;
    logic        quad_line_fetch_eff;
    logic        sec_clk_run;
    logic [1:0]  min_power_scale;
    logic [7:0]  min_power_value;
  } bgcf_ctrl_t;

endpackage : bgcf_pkg

//--- hdl/bgcf_bank.sv
// General control fields of the bridge plus one reserved byte register.
// Assumes rst_b is the fundamental reset, already combined from the
// slot reset and global_reset_n outside this block.
//
// What this block does
// - Prefetch bit clear fetches to line boundary; set fetches one dword.
// - With prefetch bit set, the quad line fetch control is ignored.
// - Prefetch bit only acts while line boundary check is enabled.
// - Shallow idle exit field bits 18:16 copies into capabilities bits 8:6.
// - Shallow exit code 000 under 64 ns, doubling, 111 above 4 us.
// - Deep idle exit field bits 15:13 copies into capabilities bits 11:9.
// - Deep exit code 000 under 1 us, doubling, 111 above 64 us.
// - Virtual channel bit 12 reads 0; next capability offset reads 000h.
// - Bit 11 set stops secondary clocks in D3; clear keeps them running.
// - Bit 10 clear wakes from L2 by WAKE only; set uses beacon too.
// - Bits 9:8 hold scale applied to the minimum power value.
// - Minimum power value bits 7:0 reset to 5Fh, meaning 0.95 W.
// - Minimum power value writable by EEPROM load and config writes.
// - Bits 15:13, 12, 11, 9:8, 7:0 reset only by fundamental reset.
// - Beacon bit 10 reset only by global or power-on reset.
// - Reserved byte at D8h resets to zero by fundamental reset only.
`timescale 1ns/1ps

module bgcf_bank (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   global_reset_n,
  input  wire bgcf_pkg::bgcf_cfg_req_t cfg_req,
  output bgcf_pkg::bgcf_cfg_rsp_t      cfg_rsp,
  input  wire logic                   eeprom_wr,
  input  wire logic [7:0]             eeprom_value,
  input  wire logic                   line_check_en,
  input  wire logic                   quad_line_fetch,
  input  wire logic                   in_d3,
  output bgcf_pkg::bgcf_ctrl_t         ctrl,
  output logic                        wake_use_beacon,
  output logic                        wake_use_wake
);
  import bgcf_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic          read_prefetch_off;
    logic [2:0]    shallow_idle_exit_limit;
    logic [2:0]    deep_idle_exit_limit;
    logic          secondary_clock_stop_in_d3;
    logic [1:0]    min_power_scale;
    logic [7:0]    min_power_value;
    logic [7:0]    reserved_vendor_cfg_a;
    bgcf_cfg_rsp_t rsp;
    bgcf_ctrl_t    ctrl;
  } bgcf_state_t;

  bgcf_state_t state;
  bgcf_state_t next_state;

  // Beacon select lives on its own reset, so it survives a fundamental
  // reset that is not also a global one.
  logic beacon_enable;
  logic next_beacon_enable;
  logic beacon_wake_out;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic        hit_gen;
  logic        hit_rsvd;
  logic [31:0] gen_word;
  logic        pref_single;

  assign hit_gen  = (cfg_req.addr == BGCF_GEN_CTRL_OFS);
  assign hit_rsvd = (cfg_req.addr == BGCF_RSVD_A_OFS);

  // Read image; the virtual channel bit is a constant zero
  always_comb begin
    gen_word = 32'h0000_0000;
    gen_word[BGCF_PREF_OFF_BIT] = state.read_prefetch_off;
    gen_word[BGCF_L0S_LSB +: 3] = state.shallow_idle_exit_limit;
    gen_word[BGCF_L1_LSB +: 3]  = state.deep_idle_exit_limit;
    gen_word[BGCF_VC_BIT]       = 1'b0;
    gen_word[BGCF_CLK_STOP_BIT] = state.secondary_clock_stop_in_d3;
    gen_word[BGCF_BEACON_BIT]   = beacon_enable;
    gen_word[BGCF_SCALE_LSB +: 2] = state.min_power_scale;
    gen_word[BGCF_VALUE_LSB +: 8] = state.min_power_value;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_beacon_enable = beacon_enable;

    // EEPROM autoload first, so a config write in the same cycle wins
    if (eeprom_wr) begin
      next_state.min_power_value = eeprom_value;
    end

    if (cfg_req.wr && hit_gen) begin
      if (cfg_req.be[0]) begin
        next_state.min_power_value =
          cfg_req.wdata[BGCF_VALUE_LSB +: 8];
      end
      if (cfg_req.be[1]) begin
        next_state.min_power_scale =
          cfg_req.wdata[BGCF_SCALE_LSB +: 2];
        next_beacon_enable = cfg_req.wdata[BGCF_BEACON_BIT];
        next_state.secondary_clock_stop_in_d3 =
          cfg_req.wdata[BGCF_CLK_STOP_BIT];
        // Bit 12 has no storage, so written data is dropped.
        next_state.deep_idle_exit_limit =
          cfg_req.wdata[BGCF_L1_LSB +: 3];
      end
      if (cfg_req.be[2]) begin
        next_state.shallow_idle_exit_limit =
          cfg_req.wdata[BGCF_L0S_LSB +: 3];
        next_state.read_prefetch_off = cfg_req.wdata[BGCF_PREF_OFF_BIT];
      end
    end

    // Kept writable; the field has no effect inside this block
    if (cfg_req.wr && hit_rsvd && cfg_req.be[0]) begin
      next_state.reserved_vendor_cfg_a = cfg_req.wdata[7:0];
    end

    // Read answer one cycle after the request; unmapped reads give zero
    next_state.rsp.rvalid = cfg_req.rd;
    next_state.rsp.rdata  = 32'h0000_0000;
    if (cfg_req.rd && hit_gen) begin
      next_state.rsp.rdata = gen_word;
    end else if (cfg_req.rd && hit_rsvd) begin
      next_state.rsp.rdata = {24'h00_0000, state.reserved_vendor_cfg_a};
    end

    // Outputs follow the stored fields one cycle behind
    next_state.ctrl.cap_shallow_exit_copy =
      state.shallow_idle_exit_limit;
    next_state.ctrl.cap_deep_exit_copy =
      state.deep_idle_exit_limit;
    next_state.ctrl.aer_next_cap = BGCF_AER_NEXT_OFF;
    next_state.ctrl.prefetch_single_dword = pref_single;
    next_state.ctrl.quad_line_fetch_eff =
      quad_line_fetch && !pref_single;
    next_state.ctrl.sec_clk_run =
      !(in_d3 && state.secondary_clock_stop_in_d3);
    next_state.ctrl.min_power_scale = state.min_power_scale;
    next_state.ctrl.min_power_value = state.min_power_value;
  end

  // Prefetch control is gated by the line boundary check
  assign pref_single = line_check_en && state.read_prefetch_off;

  // ****************************************************************
  // Fundamental reset domain
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state.read_prefetch_off          <= 1'b0;
      state.shallow_idle_exit_limit    <= BGCF_L0S_RST;
      state.deep_idle_exit_limit       <= BGCF_L1_RST;
      state.secondary_clock_stop_in_d3 <= 1'b0;
      state.min_power_scale            <= BGCF_SCALE_RST;
      state.min_power_value            <= BGCF_VALUE_RST;
      state.reserved_vendor_cfg_a      <= BGCF_RSVD_RST;
      state.rsp.rvalid                 <= 1'b0;
      state.rsp.rdata                  <= 32'h0000_0000;
      state.ctrl.cap_shallow_exit_copy <= BGCF_L0S_RST;
      state.ctrl.cap_deep_exit_copy    <= BGCF_L1_RST;
      state.ctrl.aer_next_cap          <= BGCF_AER_NEXT_OFF;
      state.ctrl.prefetch_single_dword <= 1'b0;
      state.ctrl.quad_line_fetch_eff   <= 1'b0;
      state.ctrl.sec_clk_run           <= 1'b1;
      state.ctrl.min_power_scale       <= BGCF_SCALE_RST;
      state.ctrl.min_power_value       <= BGCF_VALUE_RST;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Global reset domain
  // ****************************************************************
  always_ff @(posedge clk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      beacon_enable   <= 1'b0;
      beacon_wake_out <= 1'b0;
    end else begin
      beacon_enable   <= next_beacon_enable;
      beacon_wake_out <= beacon_enable;
    end
  end

  // WAKE is used in both modes, so its select is a constant flop
  always_ff @(posedge clk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      wake_use_wake <= 1'b1;
    end else begin
      wake_use_wake <= 1'b1;
    end
  end

  assign wake_use_beacon = beacon_wake_out;
  assign cfg_rsp         = state.rsp;
  assign ctrl            = state.ctrl;

endmodule : bgcf_bank

//--- sim/bgcf_checker.sv
// Concurrent checks on the general control field bank ports.
// Assumes a bind from the testbench top; sees the bank's ports only.
`timescale 1ns/1ps

module bgcf_checker import bgcf_pkg::*; (
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic          global_reset_n,
  input wire bgcf_cfg_req_t cfg_req,
  input wire bgcf_cfg_rsp_t cfg_rsp,
  input wire logic          eeprom_wr,
  input wire logic [7:0]    eeprom_value,
  input wire logic          line_check_en,
  input wire logic          quad_line_fetch,
  input wire logic          in_d3,
  input wire bgcf_ctrl_t    ctrl,
  input wire logic          wake_use_beacon,
  input wire logic          wake_use_wake
);
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic gen_hit = cfg_req.wr && cfg_req.addr == BGCF_GEN_CTRL_OFS;
  sequence s_wr_hi;
    gen_hit && cfg_req.be[2];
  endsequence
  sequence s_wr_mid;
    gen_hit && cfg_req.be[1];
  endsequence

  a_read_answer: assert property (cfg_req.rd |=> cfg_rsp.rvalid)
    else $error("read got no answer next cycle");
  a_vc_zero: assert property (!cfg_rsp.rdata[12])
    else $error("virtual channel bit read as one");
  a_aer_next: assert property (ctrl.aer_next_cap == 12'h000)
    else $error("next capability offset not zero");
  a_single_gated: assert property
    (!$past(line_check_en) |-> !ctrl.prefetch_single_dword)
    else $error("single dword fetch without line check");
  a_quad_masked: assert property
    (ctrl.prefetch_single_dword && $past(ctrl.prefetch_single_dword)
     |-> !ctrl.quad_line_fetch_eff)
    else $error("quad fetch active while prefetch off");
  a_clk_runs: assert property (!$past(in_d3) |-> ctrl.sec_clk_run)
    else $error("secondary clock stopped outside D3");
  a_wake_always: assert property (wake_use_wake)
    else $error("wake signal not in use");
  a_shallow_copy: assert property (s_wr_hi |-> ##2
    ctrl.cap_shallow_exit_copy == $past(cfg_req.wdata[18:16], 2))
    else $error("shallow exit copy wrong");
  a_deep_copy: assert property (s_wr_mid |-> ##2
    ctrl.cap_deep_exit_copy == $past(cfg_req.wdata[15:13], 2))
    else $error("deep exit copy wrong");
  a_beacon_follow: assert property (@(posedge clk)
    disable iff (!rst_b || !global_reset_n)
    s_wr_mid |-> ##2 wake_use_beacon == $past(cfg_req.wdata[10], 2))
    else $error("beacon use does not follow bit 10");
  a_eeprom_load: assert property
    (eeprom_wr && !(gen_hit && cfg_req.be[0])
     |-> ##2 ctrl.min_power_value == $past(eeprom_value, 2))
    else $error("eeprom value not loaded");
endmodule : bgcf_checker

//--- sim/test_bgcf_bank.sv
// Self-checking bench for the general control field bank.
// Assumes the bank and its package are compiled first.
`timescale 1ns/1ps

module test_bgcf_bank;
  import bgcf_pkg::*;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic          gr_n = 1'b0;
  bgcf_cfg_req_t req = '0;
  bgcf_cfg_rsp_t rsp;
  logic          ee_wr = 1'b0;
  logic [7:0]    ee_val = 8'h00;
  logic          lce = 1'b0;
  logic          quad = 1'b0;
  logic          d3 = 1'b0;
  bgcf_ctrl_t    ctrl;
  logic          wb;
  logic          ww;
  logic [31:0]   img;
  int            errors = 0;
  int            check_count = 0;

  bgcf_bank DUT (.clk(clk), .rst_b(rst_b), .global_reset_n(gr_n),
    .cfg_req(req), .cfg_rsp(rsp), .eeprom_wr(ee_wr), .eeprom_value(ee_val),
    .line_check_en(lce), .quad_line_fetch(quad), .in_d3(d3), .ctrl(ctrl),
    .wake_use_beacon(wb), .wake_use_wake(ww));

  always #5 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test;
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bits 31:20 and the hardwired bit 12 never store anything
  function automatic logic [31:0] merge(logic [31:0] o, logic [3:0] be,
                                        logic [31:0] d);
    logic [31:0] m;
    m = {12'h000, {4{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return ((o & ~m) | (d & m)) & 32'h000FEFFF;
  endfunction : merge

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, a, be, d};
    if (a == BGCF_GEN_CTRL_OFS) img = merge(img, be, d);
    @(posedge clk);
    #1 req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    #1 req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1 req.rd = 1'b0;
    chk({31'h0, rsp.rvalid}, 32'h1);
    chk(rsp.rdata, exp);
  endtask : rd

  task automatic chk_ctrl;
    logic ps;
    ps = lce & img[19];
    chk(ctrl.prefetch_single_dword, ps);
    chk(ctrl.quad_line_fetch_eff, quad & !ps);
    chk(ctrl.cap_shallow_exit_copy, img[18:16]);
    chk(ctrl.cap_deep_exit_copy, img[15:13]);
    chk(ctrl.sec_clk_run, !(d3 && img[11]));
    chk(wb, img[10]);
    chk({ctrl.min_power_scale, ctrl.min_power_value}, img[9:0]);
    chk(ctrl.aer_next_cap, BGCF_AER_NEXT_OFF);
    chk(ww, 1'b1);
  endtask : chk_ctrl

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h1836));
    img = 32'h0000005F;
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    gr_n = 1'b1;
    rd(BGCF_GEN_CTRL_OFS, img);
    rd(BGCF_RSVD_A_OFS, 32'h0);
    rd(8'hE0, 32'h0);
    for (int i = 0; i < 40; i++) begin
      lce = 1'($urandom);
      quad = 1'($urandom);
      d3 = 1'($urandom);
      if (i == 0) wr(BGCF_GEN_CTRL_OFS, 4'hF, 32'hFFFFFFFF);
      else if (i % 7 == 3) wr(8'hE0, 4'hF, $urandom);
      else wr(BGCF_GEN_CTRL_OFS, 4'($urandom), $urandom);
      if (i % 5 == 4) begin
        @(posedge clk);
        #1 ee_wr = 1'b1;
        ee_val = 8'($urandom);
        img[7:0] = ee_val;
        @(posedge clk);
        #1 ee_wr = 1'b0;
      end
      rd(BGCF_GEN_CTRL_OFS, img);
      chk_ctrl;
    end
    wr(BGCF_GEN_CTRL_OFS, 4'h2, 32'h00000C00);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    img = {21'h0, img[10], 10'h05F};
    rd(BGCF_GEN_CTRL_OFS, img);
    chk_ctrl;
    #1 rst_b = 1'b0;
    gr_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    gr_n = 1'b1;
    img = 32'h0000005F;
    rd(BGCF_GEN_CTRL_OFS, img);
    chk_ctrl;
    end_of_test;
  end

  // Whole run needs a few microseconds; this leaves ample margin
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule : test_bgcf_bank

bind bgcf_bank bgcf_checker u_chk (.clk(clk), .rst_b(rst_b),
  .global_reset_n(global_reset_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
  .eeprom_wr(eeprom_wr), .eeprom_value(eeprom_value),
  .line_check_en(line_check_en), .quad_line_fetch(quad_line_fetch),
  .in_d3(in_d3), .ctrl(ctrl), .wake_use_beacon(wake_use_beacon),
  .wake_use_wake(wake_use_wake));
